// ==== design/tace_edge_det.sv ====
`timescale 1ns/1ps
module tace_edge_det #(
  parameter int N = 8
) (
  input  wire logic           ref_clk_in,
  input  wire logic           sys_rst_in,
  input  wire logic [N-1:0]   pin_in,
  input  wire logic [2*N-1:0] edge_cfg_in,
  output logic      [N-1:0]   capture_out
);
  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;

  always_comb
  begin
    prev_d = pin_in;
    for (int i = 0; i < N; i++)
    begin
      capture_out[i] = (edge_cfg_in[2*i]   & pin_in[i] & ~prev_q[i]) |
                       (edge_cfg_in[2*i+1] & ~pin_in[i] & prev_q[i]);
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      prev_q <= '0;
    else
      prev_q <= prev_d;
  end
endmodule

// ==== design/tace_pin_action.sv ====
`timescale 1ns/1ps
module tace_pin_action (
  input  wire logic       cur_in,
  input  wire logic [1:0] code_in,
  output logic            next_out
);
  always_comb
  begin
    case (code_in)
      tace_pkg::ACT_TOGGLE: next_out = ~cur_in;
      tace_pkg::ACT_CLEAR:  next_out = 1'b0;
      tace_pkg::ACT_SET:    next_out = 1'b1;
      default:              next_out = cur_in;
    endcase
  end
endmodule

// ==== design/tace_pkg.sv ====
package tace_pkg;
  localparam int          NUM_CH        = 8;
  // Register indices; one register per word, byte address is the index times four
  localparam int          IDX_LSB       = 2;
  localparam logic [7:0]  A_OUT_HI      = 8'h08;
  localparam logic [7:0]  A_OUT_LO      = 8'h09;
  localparam logic [7:0]  A_EDGE_HI     = 8'h0a;
  localparam logic [7:0]  A_EDGE_LO     = 8'h0b;
  localparam logic [7:0]  A_IRQ_EN      = 8'h0c;
  localparam logic [7:0]  A_FLAGS       = 8'h0e;
  localparam logic [7:0]  A_FUNC_SEL    = 8'h10;
  localparam logic [7:0]  A_OVR_MASK    = 8'h14;
  localparam logic [7:0]  A_OVR_DATA    = 8'h18;
  localparam logic [7:0]  A_DISCONNECT  = 8'h1c;
  localparam logic [7:0]  A_PIN_STATE   = 8'h20;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam int          CH7           = 7;
  localparam logic [1:0]  ACT_NONE      = 2'b00;
  localparam logic [1:0]  ACT_TOGGLE    = 2'b01;
  localparam logic [1:0]  ACT_CLEAR     = 2'b10;
  localparam logic [1:0]  ACT_SET       = 2'b11;
  localparam logic [1:0]  EDGE_RISE     = 2'b01;
  localparam logic [1:0]  EDGE_FALL     = 2'b10;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
endpackage

// ==== design/tace_top.sv ====
`timescale 1ns/1ps
module tace_top #(
  parameter int N = 8
) (
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic [N-1:0] compare_match_in,
  input  wire logic [N-1:0] channel_pin_in,
  output logic      [N-1:0] channel_pin_out,
  output logic      [N-1:0] channel_pin_oe_out,
  output logic      [N-1:0] capture_event_out,
  output logic              irq_out
);
  logic [7:0]   out_hi_q, out_lo_q, edge_hi_q, edge_lo_q, irq_en_q, flags_q;
  logic [7:0]   out_hi_d, out_lo_d, edge_hi_d, edge_lo_d, irq_en_d, flags_d;
  logic [7:0]   func_sel_q, ovr_mask_q, ovr_data_q, disc_q;
  logic [7:0]   func_sel_d, ovr_mask_d, ovr_data_d, disc_d;
  logic [N-1:0] pin_q, pin_d, cap_q, cap_d;
  logic         wr_pend_q, wr_pend_d;
  logic [7:0]   wr_addr_q, wr_addr_d;
  logic [31:0]  hrdata_d;
  logic [N-1:0] capture;
  logic [N-1:0] compare_ev;
  logic [N-1:0] act_next;
  logic [7:0]   wbyte;
  logic         addr_ph;

  // Pair x: high register holds channels 7..4, low register 3..0
  function automatic logic [1:0] pair_of(input logic [7:0] hi, input logic [7:0] lo,
                                         input int ch);
    logic [15:0] cat;
    cat = {hi, lo};
    return cat[2*ch +: 2];
  endfunction

  function automatic logic [1:0] act_code(input int ch, input logic [7:0] hi,
                                          input logic [7:0] lo);
    logic [15:0] cat;
    cat = {hi, lo};
    return {cat[2*ch+1], cat[2*ch]};
  endfunction

  // Word-aligned bus: drop the byte lanes to get the register index
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    return addr[tace_pkg::IDX_LSB +: 8];
  endfunction

  tace_edge_det #(.N(N)) u_edge (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pin_in      (channel_pin_in),
    .edge_cfg_in ({edge_hi_q, edge_lo_q}),
    .capture_out (capture)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_act
      tace_pin_action u_act (
        .cur_in   (pin_q[g]),
        .code_in  (act_code(g, out_hi_q, out_lo_q)),
        .next_out (act_next[g])
      );
    end
  endgenerate

  assign addr_ph   = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wbyte     = hwdata[7:0];

  always_comb
  begin
    compare_ev = compare_match_in & func_sel_q;
    cap_d      = capture & ~func_sel_q;
    pin_d      = pin_q;
    for (int i = 0; i < N; i++)
    begin
      if (compare_ev[i] && !ovr_mask_q[i])
        pin_d[i] = act_next[i];
      // Override lands after own action, but the mask lets only one of the two change the pin
      if (compare_ev[tace_pkg::CH7] && ovr_mask_q[i] && func_sel_q[i])
        pin_d[i] = ovr_data_q[i];
    end
  end

  always_comb
  begin
    out_hi_d   = out_hi_q;
    out_lo_d   = out_lo_q;
    edge_hi_d  = edge_hi_q;
    edge_lo_d  = edge_lo_q;
    irq_en_d   = irq_en_q;
    func_sel_d = func_sel_q;
    ovr_mask_d = ovr_mask_q;
    ovr_data_d = ovr_data_q;
    disc_d     = disc_q;
    flags_d    = flags_q;
    wr_pend_d  = addr_ph & hwrite;
    wr_addr_d  = addr_ph ? reg_index(haddr) : wr_addr_q;
    hrdata_d   = hrdata;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        tace_pkg::A_OUT_HI:     out_hi_d   = wbyte;
        tace_pkg::A_OUT_LO:     out_lo_d   = wbyte;
        tace_pkg::A_EDGE_HI:    edge_hi_d  = wbyte;
        tace_pkg::A_EDGE_LO:    edge_lo_d  = wbyte;
        tace_pkg::A_IRQ_EN:     irq_en_d   = wbyte;
        tace_pkg::A_FLAGS:      flags_d    = flags_q & ~wbyte;
        tace_pkg::A_FUNC_SEL:   func_sel_d = wbyte;
        tace_pkg::A_OVR_MASK:   ovr_mask_d = wbyte;
        tace_pkg::A_OVR_DATA:   ovr_data_d = wbyte;
        tace_pkg::A_DISCONNECT: disc_d     = wbyte;
        default:                ;
      endcase
    end
    // Set after clear so a same-cycle event is never lost
    flags_d = flags_d | compare_ev | cap_d;
    if (addr_ph && !hwrite)
    begin
      case (reg_index(haddr))
        tace_pkg::A_OUT_HI:     hrdata_d = {24'h00_0000, out_hi_q};
        tace_pkg::A_OUT_LO:     hrdata_d = {24'h00_0000, out_lo_q};
        tace_pkg::A_EDGE_HI:    hrdata_d = {24'h00_0000, edge_hi_q};
        tace_pkg::A_EDGE_LO:    hrdata_d = {24'h00_0000, edge_lo_q};
        tace_pkg::A_IRQ_EN:     hrdata_d = {24'h00_0000, irq_en_q};
        tace_pkg::A_FLAGS:      hrdata_d = {24'h00_0000, flags_q};
        tace_pkg::A_FUNC_SEL:   hrdata_d = {24'h00_0000, func_sel_q};
        tace_pkg::A_OVR_MASK:   hrdata_d = {24'h00_0000, ovr_mask_q};
        tace_pkg::A_OVR_DATA:   hrdata_d = {24'h00_0000, ovr_data_q};
        tace_pkg::A_DISCONNECT: hrdata_d = {24'h00_0000, disc_q};
        tace_pkg::A_PIN_STATE:  hrdata_d = {24'h00_0000, pin_q};
        default:                hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      out_hi_q   <= tace_pkg::RST_BYTE;
      out_lo_q   <= tace_pkg::RST_BYTE;
      edge_hi_q  <= tace_pkg::RST_BYTE;
      edge_lo_q  <= tace_pkg::RST_BYTE;
      irq_en_q   <= tace_pkg::RST_BYTE;
      flags_q    <= tace_pkg::RST_BYTE;
      func_sel_q <= tace_pkg::RST_BYTE;
      ovr_mask_q <= tace_pkg::RST_BYTE;
      ovr_data_q <= tace_pkg::RST_BYTE;
      disc_q     <= tace_pkg::RST_BYTE;
      pin_q      <= '0;
      cap_q      <= '0;
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      hrdata     <= 32'h0000_0000;
      irq_out    <= 1'b0;
    end
    else
    begin
      out_hi_q   <= out_hi_d;
      out_lo_q   <= out_lo_d;
      edge_hi_q  <= edge_hi_d;
      edge_lo_q  <= edge_lo_d;
      irq_en_q   <= irq_en_d;
      flags_q    <= flags_d;
      func_sel_q <= func_sel_d;
      ovr_mask_q <= ovr_mask_d;
      ovr_data_q <= ovr_data_d;
      disc_q     <= disc_d;
      pin_q      <= pin_d;
      cap_q      <= cap_d;
      wr_pend_q  <= wr_pend_d;
      wr_addr_q  <= wr_addr_d;
      hrdata     <= hrdata_d;
      irq_out    <= |(flags_d & irq_en_d);
    end
  end

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      // Pin is an output when not disconnected and its mode/level pair is nonzero or ch7 overrides it
      channel_pin_oe_out[i] = ~disc_q[i] &
                              ((pair_of(out_hi_q, out_lo_q, i) != tace_pkg::ACT_NONE) |
                               (ovr_mask_q[i] & func_sel_q[i]));
    end
  end
  assign channel_pin_out   = pin_q;
  assign capture_event_out = cap_q;

  // Channel-7 compare while the override mask claims channel 0
  sequence ovr_ev_s;
    compare_ev[tace_pkg::CH7] && ovr_mask_q[0] && func_sel_q[0];
  endsequence

  // Own compare on channel 0 with no override competing for the pin
  sequence own_ev_s;
    compare_ev[0] && !ovr_mask_q[0] && !compare_ev[tace_pkg::CH7];
  endsequence

  ch7_pin_own_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (compare_ev[tace_pkg::CH7] && !ovr_mask_q[tace_pkg::CH7] &&
     act_code(tace_pkg::CH7, out_hi_q, out_lo_q) == tace_pkg::ACT_CLEAR)
    |=> !pin_q[tace_pkg::CH7])
    else $error("ch7 clear action not applied");

  ch7_ovr_pin_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (compare_ev[tace_pkg::CH7] && ovr_mask_q[tace_pkg::CH7])
    |=> pin_q[tace_pkg::CH7] == $past(ovr_data_q[tace_pkg::CH7]))
    else $error("ch7 override data not applied");

  ovr_load_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    ovr_ev_s |=> pin_q[0] == $past(ovr_data_q[0]))
    else $error("override data not loaded");

  ovr_func_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (compare_ev[tace_pkg::CH7] && ovr_mask_q[0] && !func_sel_q[0]) |=> $stable(pin_q[0]))
    else $error("override reached capture channel");

  set_act_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    own_ev_s ##0 (act_code(0, out_hi_q, out_lo_q) == tace_pkg::ACT_SET)
    |=> pin_q[0])
    else $error("set action missing");

  clear_act_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    own_ev_s ##0 (act_code(0, out_hi_q, out_lo_q) == tace_pkg::ACT_CLEAR)
    |=> !pin_q[0])
    else $error("clear action missing");

  toggle_act_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    own_ev_s ##0 (act_code(0, out_hi_q, out_lo_q) == tace_pkg::ACT_TOGGLE)
    |=> pin_q[0] != $past(pin_q[0]))
    else $error("toggle action missing");

  none_act_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    own_ev_s ##0 (act_code(0, out_hi_q, out_lo_q) == tace_pkg::ACT_NONE)
    |=> $stable(pin_q[0]))
    else $error("idle code moved the pin");

  mask_block_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (ovr_mask_q[0] && !compare_ev[tace_pkg::CH7]) |=> $stable(pin_q[0]))
    else $error("masked channel changed");

  disc_oe_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    disc_q[0] |-> !channel_pin_oe_out[0])
    else $error("disconnected pin driven");

  oe_level_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (!disc_q[0] && out_lo_q[0]) |-> channel_pin_oe_out[0])
    else $error("output enable missing for level bit");

  oe_mode_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (!disc_q[0] && out_lo_q[1]) |-> channel_pin_oe_out[0])
    else $error("output enable missing for mode bit");

  flag_set_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    compare_ev[0] |=> flags_q[0])
    else $error("flag not set on compare");

  cap_flag_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    cap_d[1] |=> flags_q[1])
    else $error("flag not set on capture");

  irq_gate_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (flags_q & irq_en_q) != 8'h00 |-> irq_out)
    else $error("irq not raised");

  irq_block_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (flags_q & irq_en_q) == 8'h00 |-> !irq_out)
    else $error("irq raised with no enabled flag");

  cap_func_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    func_sel_q[1] |=> !cap_q[1])
    else $error("capture on compare channel");

  reg_rw_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_pend_q && wr_addr_q == tace_pkg::A_EDGE_LO) |=> edge_lo_q == $past(wbyte))
    else $error("edge register write lost");

  // Only a register write can clear a flag or an enable
  irq_hold_a: assert property (
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (irq_out && !wr_pend_q) |=> irq_out)
    else $error("irq dropped without a write");
endmodule

// ==== sim/tace_pin_model.sv ====
`timescale 1ns/1ps
module tace_pin_model (
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] ext_in,
  output logic      [7:0] level_out
);
  // Driven pins follow the block, released pins the outside source
  assign level_out = (oe_in & pin_out_in) | (~oe_in & ext_in);
endmodule

// ==== sim/timer_channel_action_edge_control_tb.sv ====
`timescale 1ns/1ps
module timer_channel_action_edge_control_tb;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  cmp;
  logic [7:0]  pin_lvl;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  cap;
  logic        irq;
  logic [7:0]  ext;
  logic [31:0] rd;
  int          errors;
  int          checks_done;
  int          ncap;
  int          n0;
  logic [7:0]  regs [0:4] = '{tace_pkg::A_OUT_HI, tace_pkg::A_OUT_LO, tace_pkg::A_EDGE_HI,
                              tace_pkg::A_EDGE_LO, tace_pkg::A_IRQ_EN};
  logic [1:0]  code_t [0:4] = '{tace_pkg::ACT_SET, tace_pkg::ACT_TOGGLE, tace_pkg::ACT_CLEAR,
                                tace_pkg::ACT_TOGGLE, tace_pkg::ACT_NONE};
  logic        pin_t [0:4] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
  int          cnt_t [0:3] = '{0, 1, 1, 2};

  tace_top #(.N(8)) dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .compare_match_in(cmp), .channel_pin_in(pin_lvl),
    .channel_pin_out(pin_out), .channel_pin_oe_out(pin_oe), .capture_event_out(cap),
    .irq_out(irq)
  );
  tace_pin_model pm (.pin_out_in(pin_out), .oe_in(pin_oe), .ext_in(ext), .level_out(pin_lvl));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
    if (cap[1] === 1'h1)
      ncap <= ncap + 1;

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h00_0000, a} << tace_pkg::IDX_LSB;
    htrans <= tace_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare strobe is one cycle; pins settle well within the wait
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    cmp <= m;
    @(posedge clk);
    cmp <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    errors = 0;
    checks_done = 0;
    ncap = 0;
    hsel = 1'h0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    cmp = 8'h00;
    ext = 8'h00;
    rst = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 5; i++)
    begin
      bus(1'h0, regs[i], 32'h0);
      chk("reset value", 32'h0, rd);
      bus(1'h1, regs[i], 32'hffff_ff5a ^ i);
      bus(1'h0, regs[i], 32'h0);
      chk("read back", 32'h5a ^ i, rd);
      bus(1'h1, regs[i], 32'h0);
    end
    bus(1'h0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("response", 32'h0, hresp);
    bus(1'h1, tace_pkg::A_FUNC_SEL, 32'hff);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'h1, tace_pkg::A_OUT_LO, {30'h0, code_t[i]});
      pulse(8'h01);
      chk("pin0 action", pin_t[i], pin_out[0]);
      chk("pin0 enable", code_t[i] != 2'h0, pin_oe[0]);
    end
    // Own clear action is masked; only the override may move pin 0
    bus(1'h1, tace_pkg::A_OUT_LO, 32'h2);
    bus(1'h1, tace_pkg::A_OVR_MASK, 32'h81);
    bus(1'h1, tace_pkg::A_OVR_DATA, 32'h80);
    pulse(8'h01);
    chk("masked pin0", 1, pin_out[0]);
    pulse(8'h80);
    chk("override pin0", 0, pin_out[0]);
    chk("override pin7", 1, pin_out[7]);
    bus(1'h0, tace_pkg::A_PIN_STATE, 32'h0);
    chk("pin state", 32'h80, rd);
    bus(1'h1, tace_pkg::A_OVR_MASK, 32'h01);
    bus(1'h1, tace_pkg::A_OUT_HI, 32'h80);
    pulse(8'h80);
    chk("own pin7", 0, pin_out[7]);
    bus(1'h1, tace_pkg::A_OVR_MASK, 32'h81);
    bus(1'h1, tace_pkg::A_OVR_DATA, 32'h01);
    bus(1'h1, tace_pkg::A_FUNC_SEL, 32'hfe);
    pulse(8'h80);
    chk("capture pin0", 0, pin_out[0]);
    bus(1'h1, tace_pkg::A_OVR_MASK, 32'h0);
    bus(1'h1, tace_pkg::A_FUNC_SEL, 32'hff);
    bus(1'h1, tace_pkg::A_OUT_LO, 32'h0);
    @(posedge clk);
    chk("release pin0", 0, pin_oe[0]);
    bus(1'h1, tace_pkg::A_OUT_LO, 32'h3);
    @(posedge clk);
    chk("enable pin0", 1, pin_oe[0]);
    bus(1'h1, tace_pkg::A_DISCONNECT, 32'h1);
    pulse(8'h00);
    chk("disconnect", 0, pin_oe[0]);
    bus(1'h1, tace_pkg::A_DISCONNECT, 32'h0);
    bus(1'h1, tace_pkg::A_OUT_LO, 32'h0);
    bus(1'h1, tace_pkg::A_FUNC_SEL, 32'hfd);
    bus(1'h1, tace_pkg::A_FLAGS, 32'hff);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h1, tace_pkg::A_EDGE_LO, i << 2);
      n0 = ncap;
      @(posedge clk);
      ext <= 8'h02;
      repeat (6) @(posedge clk);
      ext <= 8'h00;
      repeat (6) @(posedge clk);
      chk("captures", cnt_t[i], ncap - n0);
    end
    bus(1'h0, tace_pkg::A_FLAGS, 32'h0);
    chk("flag1", 32'h2, rd & 32'h2);
    chk("irq disabled", 0, irq);
    bus(1'h1, tace_pkg::A_IRQ_EN, 32'h2);
    pulse(8'h00);
    chk("irq enabled", 1, irq);
    bus(1'h1, tace_pkg::A_FLAGS, 32'h2);
    pulse(8'h00);
    chk("irq cleared", 0, irq);
    // Channels 7 and 0 handed to the accumulator: compare, no pin action
    bus(1'h1, tace_pkg::A_OUT_HI, 32'h0);
    bus(1'h1, tace_pkg::A_OVR_MASK, 32'h0);
    pulse(8'h81);
    chk("accumulator pins", 8'h00, pin_oe & 8'h81);
    tally_and_finish();
  end
endmodule
